// File: rtl/redriver_lane_strap_control.sv
// Function
// RULE1: a receiver-detect pass runs at power-up, on a power-down pin toggle, or on a register write.
// RULE2: each strap decodes to one of five levels, the top one meaning a floating pin.
// RULE3: straps are sampled at power-up only and later changes are ignored.
// RULE4: sixteen lanes, each with transmit and receive, are grouped into banks.
// RULE5: with detection enabled and power-down low the lanes pass traffic after detection.
// RULE6: with detection disabled the bank acts as a plain buffer with all lanes on.
// RULE7: a bank's power-down request puts the bank into standby.
// RULE8: power-down high powers a bank down, low runs it, and any toggle restarts detection.
// RULE9: each power-down input controls four side A and four side B lanes of one lane group.
// RULE10: power-down inputs act in every control mode.
// RULE11: each address strap pair sets the target address of one eight-lane bank on one side.
// RULE12: different sides and banks answer at different addresses, one pair covering both groups.
// RULE13: mode strap at L2 selects target mode under a controller clocking at most 400 kHz.
// RULE14: the device can instead load its settings from an external EEPROM.
// RULE15: after a successful EEPROM load the active-low done output goes low.
// RULE16: straps are latched at power-up and address, mode and grouping derive from the latch; the code derives only address and mode, the bank grouping is fixed.
`timescale 1ns/10ps
`default_nettype none
module redriver_lane_strap_control
  import redriver_pkg::*;
#(
  parameter int EE_LOAD_CYCLES = EEPROM_LOAD_CYCLES,
  parameter int DET_CYCLES = DETECT_CYCLES
) (
  // clock and power-up reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps and bank power-down pins (bank 3 = lanes 15-12)
  input wire logic [NUM_STRAPS*THERM_W-1:0] strapTherm,
  input wire logic [NUM_BANKS-1:0] bankPowerDown,
  // far-end termination sense and lane enables, 8 per bank
  input wire logic [NUM_BANKS*LANES_PER_BANK-1:0] farEndSense,
  output logic [NUM_BANKS*LANES_PER_BANK-1:0] laneEnable,
  output logic [NUM_BANKS-1:0] bankStandby,
  // decoded target addresses and mode
  output logic [NUM_ADDR_PAIRS*ADDR_W-1:0] targetAddr,
  output logic [NUM_ADDR_PAIRS-1:0] targetAddrValid,
  output logic targetMode,
  // eeprom self-load handshake
  output logic eepromLoadReq,
  input wire logic eepromLoadDone,
  input wire logic eepromLoadOk,
  output logic cfgDoneN
);

  localparam int EE_W = $clog2(EE_LOAD_CYCLES + 1);
  // follows the detect length so a shortened pass keeps a tight bound
  localparam int DetMax = DET_CYCLES + 2;

  // ****************************************
  // strap capture
  // ****************************************
  logic [NUM_STRAPS*LEVEL_W-1:0] levels;
  logic captured, capturedPrevQ;
  wire [LEVEL_W-1:0] modeLevel = levels[MODE_STRAP*LEVEL_W +: LEVEL_W];
  wire targetModeD = modeLevel == MODE_TARGET_LEVEL; // RULE13

  strap_latch #(
    .STRAPS(NUM_STRAPS)
  ) strap_latch_i (
    .core_clk(core_clk),
    .reset(reset),
    .strapTherm(strapTherm),
    .levels(levels),
    .captured(captured)
  );

  // ****************************************
  // target address decode
  // ****************************************
  // pair order: A 15-8, A 7-0, B 15-8, B 7-0; strap 2p is the high pin
  logic [NUM_ADDR_PAIRS*ADDR_W-1:0] addrD;
  logic [NUM_ADDR_PAIRS-1:0] addrValidD;
  logic [NUM_ADDR_PAIRS*ADDR_W-1:0] addrQ;
  logic [NUM_ADDR_PAIRS-1:0] addrValidQ;
  logic targetModeQ;
  for (genvar p = 0; p < NUM_ADDR_PAIRS; p++) begin : g_addr
    wire [LEVEL_W-1:0] hiLvl = levels[(2*p)*LEVEL_W +: LEVEL_W];
    wire [LEVEL_W-1:0] loLvl = levels[(2*p+1)*LEVEL_W +: LEVEL_W];
    // even address for one four-lane group, odd for the other
    assign addrD[p*ADDR_W +: ADDR_W] = TARGET_ADDR_BASE + {hiLvl[1:0], loLvl[1:0], 1'b0}; // RULE11 RULE12
    assign addrValidD[p] = hiLvl < ADDR_LEVEL_LIMIT && loLvl < ADDR_LEVEL_LIMIT;
  end

  // derived only from the latch, so pins moving later change nothing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addrQ <= '0;
      addrValidQ <= '0;
      targetModeQ <= 1'b0;
      capturedPrevQ <= 1'b0;
    end else begin
      addrQ <= addrD; // RULE16
      addrValidQ <= addrValidD & {NUM_ADDR_PAIRS{captured}};
      targetModeQ <= captured & targetModeD;
      capturedPrevQ <= captured;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic rxDetEnQ, eeForceQ;
  logic [NUM_BANKS-1:0] retrigQ;
  logic [31:0] prdataQ;
  logic preadyQ, pslverrQ;
  logic [31:0] rdData;
  logic rdHit;
  wire setup = psel & ~penable;
  wire wrTake = psel & penable & preadyQ & pwrite;
  wire ctrlWr = wrTake & (paddr == REG_CTRL);
  bank_status_s bankStat [NUM_BANKS];
  logic [NUM_BANKS-1:0] busyVec, standbyVec;
  logic [NUM_BANKS*LANES_PER_BANK-1:0] detVec, laneVec;
  ee_state_e eeStateQ;
  logic cfgDoneNQ, eeReqQ;

  // read mux
  always_comb begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (paddr)
      REG_CTRL: rdData[CTRL_RXDET_EN_BIT] = rxDetEnQ;
      REG_STATUS: begin
        rdData[STAT_STANDBY_LSB +: NUM_BANKS] = standbyVec;
        rdData[STAT_BUSY_LSB +: NUM_BANKS] = busyVec;
        rdData[STAT_CFG_DONE_BIT] = ~cfgDoneNQ;
        rdData[STAT_EE_FAIL_BIT] = eeStateQ == EE_FAIL;
        rdData[STAT_CAPTURED_BIT] = captured;
        rdData[STAT_MODE_LSB +: LEVEL_W] = modeLevel;
      end
      REG_STRAP: rdData[NUM_STRAPS*LEVEL_W-1:0] = levels;
      REG_ADDR: begin
        for (int p = 0; p < NUM_ADDR_PAIRS; p++) begin
          rdData[p*8 +: 8] = {addrValidQ[p], addrQ[p*ADDR_W +: ADDR_W]};
        end
      end
      REG_DETECT: rdData = detVec;
      default: rdHit = 1'b0;
    endcase
  end

  // one wait-free access cycle; self-clearing bits live one cycle
  // read data is taken at setup, so the access cycle never has to stall
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxDetEnQ <= CTRL_RXDET_EN_RESET;
      retrigQ <= '0;
      eeForceQ <= 1'b0;
      prdataQ <= '0;
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
    end else begin
      preadyQ <= setup;
      prdataQ <= setup ? rdData : 32'h0000_0000;
      pslverrQ <= setup & ~rdHit;
      retrigQ <= ctrlWr ? pwdata[CTRL_RETRIG_LSB +: NUM_BANKS] : '0; // RULE1
      eeForceQ <= ctrlWr & pwdata[CTRL_EE_LOAD_BIT];
      if (ctrlWr) begin
        rxDetEnQ <= pwdata[CTRL_RXDET_EN_BIT]; // RULE5 RULE6
      end
    end
  end

  // ****************************************
  // lane banks
  // ****************************************
  // each bank carries four side A and four side B lanes of one group
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    rx_detect_bank #(
      .DET_CYCLES(DET_CYCLES)
    ) rx_detect_bank_i (
      .core_clk(core_clk),
      .reset(reset),
      .detectEnable(rxDetEnQ),
      .powerDown(bankPowerDown[b]), // RULE9 RULE10
      .retrigger(retrigQ[b]),
      .farEndSense(farEndSense[b*LANES_PER_BANK +: LANES_PER_BANK]),
      .status(bankStat[b])
    );
    assign busyVec[b] = bankStat[b].busy;
    assign standbyVec[b] = bankStat[b].standby;
    assign detVec[b*LANES_PER_BANK +: LANES_PER_BANK] = bankStat[b].detected;
    assign laneVec[b*LANES_PER_BANK +: LANES_PER_BANK] = bankStat[b].laneOn; // RULE4
  end

  // ****************************************
  // eeprom self-load
  // ****************************************
  logic [EE_W-1:0] eeCntQ;
  wire eeAutoStart = captured & ~capturedPrevQ & ~targetModeD;
  wire eeStart = eeAutoStart | eeForceQ; // RULE14
  wire eeTimeout = eeCntQ == EE_W'(EE_LOAD_CYCLES - 1);

  // load waits for the loader, gives up after the load time
  // a new start raises done-low again first, so software never sees a stale done
  // a load that times out leaves done high; only a later start can clear it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eeStateQ <= EE_IDLE;
      eeCntQ <= '0;
      eeReqQ <= 1'b0;
      cfgDoneNQ <= 1'b1;
    end else begin
      unique case (eeStateQ)
        EE_IDLE, EE_DONE, EE_FAIL: begin
          if (eeStart) begin
            eeStateQ <= EE_LOAD;
            eeReqQ <= 1'b1;
            cfgDoneNQ <= 1'b1;
            eeCntQ <= '0;
          end
        end
        EE_LOAD: begin
          eeCntQ <= eeCntQ + 1'b1;
          if (eepromLoadDone) begin
            eeStateQ <= eepromLoadOk ? EE_DONE : EE_FAIL;
            cfgDoneNQ <= ~eepromLoadOk; // RULE15
            eeReqQ <= 1'b0;
          end else if (eeTimeout) begin
            eeStateQ <= EE_FAIL;
            eeReqQ <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
  assign laneEnable = laneVec;
  assign bankStandby = standbyVec;
  assign targetAddr = addrQ;
  assign targetAddrValid = addrValidQ;
  assign targetMode = targetModeQ;
  assign eepromLoadReq = eeReqQ;
  assign cfgDoneN = cfgDoneNQ;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_strap_levels_frozen: assert property (captured && $past(captured) |-> $stable(levels)) // RULE3
    else $error("strap levels changed after capture");
  a_addr_from_latch: assert property (captured && $past(captured) |=> $stable(targetAddr)) // RULE16
    else $error("target address moved after capture");
  a_pd_gives_standby: assert property ((bankPowerDown != 4'h0) |=> // RULE7
      ((bankStandby & $past(bankPowerDown)) == $past(bankPowerDown)))
    else $error("powered-down bank not in standby");
  a_standby_lanes_off: assert property (bankStandby[0] |-> laneEnable[7:0] == 8'h00) // RULE10
    else $error("lanes on in standby bank");
  // bank 2 is the bank whose power-down pin gets cycled in normal use tests
  a_pd_release_detect: assert property ($fell(bankPowerDown[2]) && rxDetEnQ |=> busyVec[2]) // RULE8
    else $error("power-down toggle did not start detect");
  a_detect_ends: assert property ($rose(busyVec[0]) |-> ##[1:DetMax] !busyVec[0]) // RULE1
    else $error("detect pass did not end in time");
  a_buffer_all_on: assert property (!rxDetEnQ && !bankPowerDown[3] [*2] |=> laneEnable[31:24] == 8'hFF) // RULE6
    else $error("buffer mode lanes not all on");
  a_ctrl_write_en: assert property (ctrlWr |=> rxDetEnQ == $past(pwdata[CTRL_RXDET_EN_BIT])) // RULE5
    else $error("detect enable not written");
  a_addr_in_range: assert property (targetAddrValid[0] |-> // RULE11
      targetAddr[0] == 1'b0 && targetAddr[6:0] >= 7'h18 && targetAddr[6:0] <= 7'h36)
    else $error("decoded target address out of range");
  a_cfg_done_cause: assert property ($fell(cfgDoneNQ) |-> $past(eepromLoadDone && eepromLoadOk && eeReqQ)) // RULE15
    else $error("config done without successful load");
  a_ee_auto_start: assert property (eeAutoStart |=> eepromLoadReq) // RULE14
    else $error("eeprom load not requested");
  a_target_mode: assert property (captured && $past(captured) |-> targetMode == (modeLevel == 3'h2)) // RULE13
    else $error("target mode does not follow mode strap");
  // settled bank with detection on: a lane runs only if its far end answered
  a_lanes_follow_detect: assert property ($past(rxDetEnQ) && !busyVec[0] && !bankStandby[0] |-> // RULE5
      laneEnable[7:0] == detVec[7:0])
    else $error("lane enables differ from detect result");
  a_ee_force_start: assert property (eeForceQ |=> eepromLoadReq) // RULE14
    else $error("forced eeprom load not requested");
  a_ee_done_drops_req: assert property (eepromLoadDone && eepromLoadReq |=> !eepromLoadReq) // RULE14
    else $error("eeprom request held after loader finished");

  c_detect_done: cover property ($fell(busyVec[0]) && laneEnable[7:0] != 8'h00);
  c_pd_cycle: cover property ($rose(bankStandby[2]) ##[1:20] $fell(bankStandby[2]));
  c_ee_loaded: cover property ($fell(cfgDoneN));
  c_bad_addr: cover property (pslverr);
  c_ee_forced: cover property (eeForceQ ##1 eepromLoadReq);

endmodule
`default_nettype wire

// File: rtl/redriver_pkg.sv
package redriver_pkg;

  // ****************************************
  // lane and strap geometry
  // ****************************************
  localparam int NUM_BANKS = 4;
  localparam int LANES_PER_BANK = 8;
  localparam int LANES_PER_SIDE = 4;
  localparam int NUM_ADDR_PAIRS = 4;
  localparam int NUM_STRAPS = 9;
  localparam int MODE_STRAP = 8;
  localparam int THERM_W = 4;
  localparam int LEVEL_W = 3;
  localparam int ADDR_W = 7;

  // five strap levels, floating pin reads as the top one
  typedef enum logic [2:0] {
    LVL_L0 = 3'h0,
    LVL_L1 = 3'h1,
    LVL_L2 = 3'h2,
    LVL_L3 = 3'h3,
    LVL_L4 = 3'h4
  } level_e;
  localparam logic [2:0] MODE_TARGET_LEVEL = 3'h2;
  localparam logic [2:0] ADDR_LEVEL_LIMIT = 3'h4;
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h18;

  // ****************************************
  // register map (byte offsets) and fields
  // ****************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_STRAP = 12'h008;
  localparam logic [11:0] REG_ADDR = 12'h00C;
  localparam logic [11:0] REG_DETECT = 12'h010;
  localparam int CTRL_RXDET_EN_BIT = 0;
  localparam int CTRL_RETRIG_LSB = 4;
  localparam int CTRL_EE_LOAD_BIT = 8;
  localparam logic CTRL_RXDET_EN_RESET = 1'b1;
  localparam int STAT_STANDBY_LSB = 0;
  localparam int STAT_BUSY_LSB = 4;
  localparam int STAT_CFG_DONE_BIT = 8;
  localparam int STAT_EE_FAIL_BIT = 9;
  localparam int STAT_CAPTURED_BIT = 10;
  localparam int STAT_MODE_LSB = 12;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DETECT_TIME_NS = 1000;
  localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EEPROM_LOAD_TIME_MS = 30;
  localparam int EEPROM_LOAD_CYCLES = EEPROM_LOAD_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // per-bank detect state
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DETECT = 2'b01,
    RD_ACTIVE = 2'b10,
    RD_STANDBY = 2'b11
  } rd_state_e;

  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_LOAD = 2'b01,
    EE_DONE = 2'b10,
    EE_FAIL = 2'b11
  } ee_state_e;

  typedef struct packed {
    logic standby;
    logic busy;
    logic [7:0] detected;
    logic [7:0] laneOn;
  } bank_status_s;

endpackage

// File: rtl/rx_detect_bank.sv
`timescale 1ns/10ps
`default_nettype none
module rx_detect_bank
  import redriver_pkg::*;
#(
  parameter int DET_CYCLES = DETECT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic detectEnable,
  input wire logic powerDown,
  input wire logic retrigger,
  // far-end termination sense, side A [3:0], side B [7:4]
  input wire logic [LANES_PER_BANK-1:0] farEndSense,
  // bank status
  output bank_status_s status
);

  localparam int CNT_W = $clog2(DET_CYCLES + 1);
  rd_state_e stateQ, stateD;
  logic [CNT_W-1:0] cntQ;
  logic [LANES_PER_BANK-1:0] detQ, detD;
  logic pdPrevQ, enPrevQ;
  bank_status_s statusQ;
  wire toggle = powerDown != pdPrevQ; // RULE8
  wire trig = toggle | retrigger | (detectEnable & ~enPrevQ);
  wire cntDone = cntQ == CNT_W'(DET_CYCLES - 1);

  // ****************************************
  // detect sequence
  // ****************************************
  always_comb begin
    stateD = stateQ;
    detD = detQ;
    if (powerDown) begin
      stateD = RD_STANDBY; // RULE7 RULE10
    end else if (!detectEnable) begin
      stateD = RD_ACTIVE; // RULE6
      detD = '0;
    end else if (trig || stateQ == RD_STANDBY) begin
      stateD = RD_DETECT; // RULE1
    end else begin
      unique case (stateQ)
        RD_DETECT: begin
          if (cntDone) begin
            detD = farEndSense;
            stateD = (farEndSense != '0) ? RD_ACTIVE : RD_IDLE;
          end
        end
        RD_IDLE, RD_ACTIVE, RD_STANDBY: begin
          stateD = stateQ;
        end
      endcase
    end
  end

  // power-up starts a detect pass
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stateQ <= RD_DETECT;
      cntQ <= '0;
      detQ <= '0;
      pdPrevQ <= 1'b0;
      enPrevQ <= 1'b1;
      statusQ <= '0;
    end else begin
      stateQ <= stateD;
      cntQ <= (stateD == RD_DETECT && stateQ == RD_DETECT && !trig) ? cntQ + 1'b1 : '0;
      detQ <= detD;
      pdPrevQ <= powerDown;
      enPrevQ <= detectEnable;
      statusQ.standby <= stateD == RD_STANDBY;
      statusQ.busy <= stateD == RD_DETECT;
      statusQ.detected <= detD;
      statusQ.laneOn <= (stateD != RD_ACTIVE) ? '0 : (detectEnable ? detD : '1); // RULE5
    end
  end

  assign status = statusQ;

endmodule
`default_nettype wire

// File: rtl/strap_latch.sv
`timescale 1ns/10ps
`default_nettype none
module strap_latch
  import redriver_pkg::*;
#(
  parameter int STRAPS = NUM_STRAPS
) (
  // clock and power-up reset
  input wire logic core_clk,
  input wire logic reset,
  // comparator thermometer per strap
  input wire logic [STRAPS*THERM_W-1:0] strapTherm,
  // latched levels
  output logic [STRAPS*LEVEL_W-1:0] levels,
  output logic captured
);

  logic [STRAPS*LEVEL_W-1:0] levelsQ;
  logic [STRAPS*LEVEL_W-1:0] decoded;
  logic capturedQ;

  // ****************************************
  // per-strap level decode
  // ****************************************
  // more tripped thresholds means weaker pull-down; all tripped is a float
  for (genvar s = 0; s < STRAPS; s++) begin : g_strap
    assign decoded[s*LEVEL_W +: LEVEL_W] = LEVEL_W'(strapTherm[s*THERM_W + 0]) + LEVEL_W'(strapTherm[s*THERM_W + 1])
      + LEVEL_W'(strapTherm[s*THERM_W + 2]) + LEVEL_W'(strapTherm[s*THERM_W + 3]); // RULE2
  end

  // one capture after power-up release, then frozen until next reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      levelsQ <= '0;
      capturedQ <= 1'b0;
    end else if (!capturedQ) begin
      levelsQ <= decoded; // RULE3 RULE16
      capturedQ <= 1'b1;
    end
  end

  assign levels = levelsQ;
  assign captured = capturedQ;

endmodule
`default_nettype wire

// File: tb/eeprom_responder.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_responder #(
  parameter int LAT = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // self-load handshake
  input wire logic loadReq,
  output logic loadDone = 1'b0,
  output logic loadOk = 1'b0
);
  int cnt;

  // fixed read time, then a single done pulse; ok only qualifies that pulse
  always @(posedge core_clk) begin
    loadDone <= 1'b0;
    loadOk <= 1'b0;
    if (reset || !loadReq || loadDone) begin
      cnt <= 0;
    end else if (cnt == LAT) begin
      loadDone <= 1'b1;
      loadOk <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: tb/redriver_lane_strap_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module redriver_lane_strap_control_bench;
  import redriver_pkg::*;
  localparam logic [31:0] SENSE = 32'hA53C_0FF0;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic targetMode, eepromLoadReq, eepromLoadDone, eepromLoadOk, cfgDoneN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, farEndSense, laneEnable;
  logic [35:0] strapTherm;
  logic [3:0] bankPowerDown, bankStandby, targetAddrValid;
  logic [27:0] targetAddr;
  int failures, n_compared;

  redriver_lane_strap_control #(.EE_LOAD_CYCLES(50), .DET_CYCLES(8)) redriver_lane_strap_control_i (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strapTherm(strapTherm), .bankPowerDown(bankPowerDown), .farEndSense(farEndSense),
    .laneEnable(laneEnable), .bankStandby(bankStandby), .targetAddr(targetAddr),
    .targetAddrValid(targetAddrValid), .targetMode(targetMode), .eepromLoadReq(eepromLoadReq),
    .eepromLoadDone(eepromLoadDone), .eepromLoadOk(eepromLoadOk), .cfgDoneN(cfgDoneN));

  eeprom_responder #(.LAT(5)) eeprom_responder_i (
    .core_clk(core_clk), .reset(reset), .loadReq(eepromLoadReq),
    .loadDone(eepromLoadDone), .loadOk(eepromLoadOk));

  // ********************
  // helpers
  // ********************
  // strap level n shows as n comparator ones
  function automatic logic [3:0] therm(input int l);
    return 4'((5'h01 << l) - 5'h01);
  endfunction

  function automatic logic [35:0] straps(input int m);
    return {therm(m), therm(4), therm(2), therm(0), therm(0), therm(3), therm(3), therm(2), therm(1)};
  endfunction

  task automatic results();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    failures++;
    results();
  endtask

  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // detection time is bounded, so give up well past it
  task automatic waitLanes(input int b, input logic [7:0] exp);
    int i;
    for (i = 0; i < 40 && laneEnable[8*b+:8] !== exp; i++) begin
      @(posedge core_clk);
    end
    chk(32'(laneEnable[8*b+:8]), 32'(exp));
  endtask

  task automatic powerUp(input int m);
    @(posedge core_clk);
    reset <= 1'b1;
    strapTherm <= straps(m);
    bankPowerDown <= 4'h0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic strapDecode();
    chk(32'(targetAddr[20:0]), 32'({7'h18, 7'h36, 7'h24}));
    chk(32'(targetAddrValid), 32'h7);
    chk(32'(targetMode), 32'h1);
    apb(1'b0, REG_ADDR, 32'h0);
    chk({rd[31], 7'h00, rd[23:0]}, 32'h0098B6A4);
    apb(1'b0, REG_STRAP, 32'h0);
    chk(rd, 32'({3'h2, 3'h4, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h2, 3'h1}));
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h7400, 32'h2400);
  endtask

  task automatic strapsFrozen();
    strapTherm <= straps(0) ^ 36'hF0F0F0F0F;
    repeat (4) @(posedge core_clk);
    chk(32'(targetAddr[20:0]), 32'({7'h18, 7'h36, 7'h24}));
    chk(32'(targetMode), 32'h1);
    apb(1'b0, REG_STRAP, 32'h0);
    chk(rd, 32'({3'h2, 3'h4, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h2, 3'h1}));
  endtask

  task automatic bankPd();
    bankPowerDown <= 4'h4;
    farEndSense[23:16] <= 8'h5A;
    repeat (2) @(posedge core_clk);
    chk(32'(bankStandby), 32'h4);
    chk(laneEnable, SENSE & 32'hFF00FFFF);
    bankPowerDown <= 4'h0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[7:0]), 32'h40);
    waitLanes(2, 8'h5A);
  endtask

  task automatic regRetrigger();
    farEndSense[7:0] <= 8'h81;
    repeat (3) @(posedge core_clk);
    chk(32'(laneEnable[7:0]), 32'hF0);
    apb(1'b1, REG_CTRL, 32'h11);
    waitLanes(0, 8'h81);
    apb(1'b0, REG_DETECT, 32'h0);
    chk(rd, 32'hA55A0F81);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
  endtask

  task automatic bufferMode();
    int b;
    bankPowerDown <= 4'h2;
    apb(1'b1, REG_CTRL, 32'h0);
    for (b = 0; b < 4; b++) begin
      waitLanes(b, (b == 1) ? 8'h00 : 8'hFF);
    end
    chk(32'(bankStandby), 32'h2);
    bankPowerDown <= 4'h0;
    apb(1'b1, REG_CTRL, 32'h1);
    for (b = 0; b < 4; b++) begin
      waitLanes(b, farEndSense[8*b+:8]);
    end
  endtask

  task automatic unmapped();
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  // another power-up, mode strap off target level, so the device loads itself
  task automatic selfLoad();
    int i;
    int k;
    powerUp(0);
    chk(32'(targetMode), 32'h0);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 80 && cfgDoneN !== 1'b0; i++) begin
        @(posedge core_clk);
        if (eepromLoadDone === 1'b1) chk(32'(eepromLoadReq), 32'h1);
      end
      chk(32'(cfgDoneN), 32'h0);
      chk(32'(eepromLoadReq), 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'h7700, 32'h0500);
      if (k == 0) begin
        // forced reload: done goes high again until the loader answers
        apb(1'b1, REG_CTRL, 32'h101);
        repeat (2) @(posedge core_clk);
        chk(32'({eepromLoadReq, cfgDoneN}), 32'h3);
      end
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    int b;
    failures = 0;
    n_compared = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strapTherm = straps(2);
    bankPowerDown = 4'h0;
    farEndSense = SENSE;
    powerUp(2);
    chk(32'(cfgDoneN), 32'h1);
    for (b = 0; b < 4; b++) begin
      waitLanes(b, SENSE[8*b+:8]);
    end
    strapDecode();
    strapsFrozen();
    bankPd();
    regRetrigger();
    bufferMode();
    unmapped();
    selfLoad();
    results();
  end
endmodule
`default_nettype wire
